// ==== cycle_timer.sv ====
/*
 * Down counter: a start loads a cycle count, done pulses for one
 * cycle one cycle more than that count after the start. A new start restarts it.
 * Assumes a count of at least one.
 */
`timescale 1ns/1ns
module cycle_timer
  import flash_host_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  cycle_timer_if.tmr tif
);

  logic [TIMER_W-1:0] cnt_reg;
  logic [TIMER_W-1:0] cnt_next;
  logic done_reg;
  logic done_next;

  always_comb
  begin
    cnt_next = cnt_reg;
    done_next = 1'b0;
    if (tif.start)
      cnt_next = tif.cycles;
    else if (cnt_reg != '0)
    begin
      cnt_next = cnt_reg - TIMER_W'(1);
      done_next = (cnt_reg == TIMER_W'(1));
    end
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      cnt_reg <= '0;
      done_reg <= 1'b0;
    end
    else
    begin
      cnt_reg <= cnt_next;
      done_reg <= done_next;
    end
  end

  assign tif.done = done_reg;

endmodule : cycle_timer

// ==== cycle_timer_if.sv ====
/*
 * Carrier between the flash host sequencer and its cycle timer.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/1ns
interface cycle_timer_if;
  import flash_host_pkg::*;
  logic start;
  logic [TIMER_W-1:0] cycles;
  logic done;
  modport ctl (output start, output cycles, input done);
  modport tmr (input start, input cycles, output done);
endinterface : cycle_timer_if

// ==== flash_host.sv ====
/*
 * Host controller for an asynchronous multi-bank page-mode NOR flash.
 * Turns single read/write requests into timed pin cycles, tracks the
 * open page, standby, automatic sleep, hardware reset and acceleration.
 * Assumes the flash pins are wired straight to this block's pin ports.
 */
// Operation
// - Reads drive output enable and chip enable low, write enable high.
// - Command writes drive write enable and chip enable low, OE high.
// - In unlock bypass a word program takes two write cycles.
// - Apply high voltage only while accelerating, else hold pin at supply.
`timescale 1ns/1ns
module flash_host
  import flash_host_pkg::*;
#(
  parameter bit DUAL_ENABLE = 1'b0,
  parameter int ACC_CYC = max2(max2(cyc_up(ADDRESS_ACCESS_DELAY_NS), cyc_up(T_CE_NS)), cyc_up(T_OE_NS)),
  parameter int PACC_CYC = max2(cyc_up(PAGE_ACCESS_DELAY_NS), cyc_up(T_OE_NS)),
  parameter int WP_CYC = cyc_up(T_WP_NS),
  parameter int WPH_CYC = cyc_up(T_WPH_NS),
  parameter int RP_CYC = cyc_up(T_RP_NS),
  parameter int RH_CYC = cyc_up(T_RH_NS),
  parameter int SLEEP_CYC = cyc_up(ADDRESS_ACCESS_DELAY_NS + T_SLEEP_EXTRA_NS)
)
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic [ADDR_W-1:0] req_addr,
  input wire logic [DATA_W-1:0] req_wdata,
  output logic req_ready,
  output logic rsp_valid,
  output logic [DATA_W-1:0] rsp_rdata,
  output logic [1:0] rsp_bank,
  input wire logic standby_req,
  input wire logic reset_req,
  input wire logic accel_req,
  output logic lower_half_select_n,
  output logic upper_half_select_n,
  output logic oe_n,
  output logic we_n,
  output logic flash_reset_n,
  output logic accelerate_high_voltage,
  output logic [ADDR_W-1:0] addr_pin,
  input wire logic [DATA_W-1:0] dq_in,
  output logic [DATA_W-1:0] dq_out,
  output logic dq_oe
);

  typedef enum logic [3:0] {
    S_RST_BEGIN, S_RST_HOLD, S_RST_REC, S_IDLE, S_RD_WAIT, S_RD_SAMPLE,
    S_WR_SETUP, S_WR_PULSE, S_WR_HOLD
  } state_t;

  cycle_timer_if tif ();
  cycle_timer u_timer (.clk(clk), .resetn(resetn), .tif(tif.tmr));

  state_t state_reg, state_next;
  logic req_ready_next, rsp_valid_next;
  logic [DATA_W-1:0] rsp_rdata_next, dq_out_next;
  logic [1:0] rsp_bank_next;
  logic lo_n_next, up_n_next, oe_n_next, we_n_next, frst_n_next, acc_next, dq_oe_next;
  logic [ADDR_W-1:0] addr_next;
  logic [ADDR_W-PAGE_LSB-1:0] page_reg, page_next;
  logic page_valid_reg, page_valid_next;
  logic [TIMER_W-1:0] sleep_cnt_reg, sleep_cnt_next;
  logic [DATA_W-1:0] dq_s1_reg, dq_s2_reg, dq_s3_reg;
  logic hit;
  logic upper_half;

  ////////////////////////////////////////////////////////////////////////////
  // Data input synchroniser

  always_ff @(posedge clk)
  begin
    dq_s1_reg <= dq_in;
    dq_s2_reg <= dq_s1_reg;
    dq_s3_reg <= dq_s2_reg;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer

  // page is address from bit 3 up
  // A sleeping flash needs the full delay again
  assign hit = page_valid_reg && (page_reg == req_addr[ADDR_W-1:PAGE_LSB])
               && (sleep_cnt_reg < TIMER_W'(SLEEP_CYC - 1));
  assign upper_half = DUAL_ENABLE && req_addr[ADDR_W-1];

  always_comb
  begin
    state_next = state_reg;
    req_ready_next = 1'b0;
    rsp_valid_next = 1'b0;
    rsp_rdata_next = rsp_rdata;
    rsp_bank_next = rsp_bank;
    lo_n_next = lower_half_select_n;
    up_n_next = upper_half_select_n;
    oe_n_next = oe_n;
    we_n_next = 1'b1;
    frst_n_next = flash_reset_n;
    dq_out_next = dq_out;
    dq_oe_next = 1'b0;
    addr_next = addr_pin;
    page_next = page_reg;
    page_valid_next = page_valid_reg;
    sleep_cnt_next = sleep_cnt_reg;
    tif.start = 1'b0;
    tif.cycles = TIMER_W'(1);
    // otherwise the pin rests at supply level
    acc_next = accel_req;
    // sleep timer runs from the last address change, in every state
    if (sleep_cnt_reg >= TIMER_W'(SLEEP_CYC))
      page_valid_next = 1'b0;
    else
      sleep_cnt_next = sleep_cnt_reg + TIMER_W'(1);
    unique case (state_reg)
      S_RST_BEGIN:
      begin
        frst_n_next = 1'b0;
        lo_n_next = 1'b1;
        up_n_next = 1'b1;
        oe_n_next = 1'b1;
        page_valid_next = 1'b0;
        tif.start = 1'b1;
        tif.cycles = TIMER_W'(RP_CYC);
        state_next = S_RST_HOLD;
      end
      S_RST_HOLD:
      begin
        if (tif.done)
        begin
          frst_n_next = 1'b1;
          tif.start = 1'b1;
          tif.cycles = TIMER_W'(RH_CYC);
          state_next = S_RST_REC;
        end
      end
      S_RST_REC:
      begin
        if (tif.done)
        begin
          req_ready_next = 1'b1;
          state_next = S_IDLE;
        end
      end
      S_IDLE:
      begin
        req_ready_next = 1'b1;
        oe_n_next = 1'b1;
        if (reset_req)
        begin
          req_ready_next = 1'b0;
          state_next = S_RST_BEGIN;
        end
        else if (req_valid && req_ready)
        begin
          req_ready_next = 1'b0;
          addr_next = req_addr;
          sleep_cnt_next = '0;
          // choose the half by the top address bit
          lo_n_next = upper_half;
          up_n_next = !upper_half;
          rsp_bank_next = bank_of(req_addr[ADDR_W-1 -: BANK_BITS], DUAL_ENABLE);
          if (req_write)
          begin
            // bypass, erase and program sequences are user write cycles
            // sector and bank targets come in the user address
            dq_out_next = req_wdata;
            dq_oe_next = 1'b1;
            page_valid_next = 1'b0;
            state_next = S_WR_SETUP;
          end
          else
          begin
            // read cycle, write enable stays high
            oe_n_next = 1'b0;
            tif.start = 1'b1;
            // wait covers address, enable and output enable delays
            // same page uses the short delay
            // no extra wait when the bank changes
            tif.cycles = hit ? TIMER_W'(PACC_CYC + SYNC_LAT) : TIMER_W'(ACC_CYC + SYNC_LAT);
            page_next = req_addr[ADDR_W-1:PAGE_LSB];
            page_valid_next = 1'b1;
            state_next = S_RD_WAIT;
          end
        end
        else if (standby_req)
        begin
          // both enables high puts the flash in standby
          // the next access then pays the full delay
          // safe even while a program or erase runs
          lo_n_next = 1'b1;
          up_n_next = 1'b1;
          page_valid_next = 1'b0;
        end
      end
      S_RD_WAIT:
      begin
        if (tif.done)
          state_next = S_RD_SAMPLE;
      end
      S_RD_SAMPLE:
      begin
        // all sixteen bits taken, autoselect or array alike
        if (dq_s2_reg == dq_s3_reg)
        begin
          // read data is array data unless a command changed mode
          rsp_rdata_next = dq_s3_reg;
          rsp_valid_next = 1'b1;
          oe_n_next = 1'b1;
          state_next = S_IDLE;
        end
      end
      S_WR_SETUP:
      begin
        // write enable low only while output enable is high
        // data driven only with output enable high
        dq_oe_next = 1'b1;
        we_n_next = 1'b0;
        tif.start = 1'b1;
        tif.cycles = TIMER_W'(WP_CYC);
        state_next = S_WR_PULSE;
      end
      S_WR_PULSE:
      begin
        dq_oe_next = 1'b1;
        we_n_next = tif.done;
        if (tif.done)
        begin
          tif.start = 1'b1;
          tif.cycles = TIMER_W'(WPH_CYC);
          state_next = S_WR_HOLD;
        end
      end
      S_WR_HOLD:
      begin
        // release the bus once the hold time has passed
        dq_oe_next = !tif.done;
        if (tif.done)
        begin
          rsp_valid_next = 1'b1;
          req_ready_next = 1'b1;
          state_next = S_IDLE;
        end
      end
      default:
        state_next = S_RST_BEGIN;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      state_reg <= S_RST_BEGIN;
      req_ready <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_rdata <= '0;
      rsp_bank <= BANK_A;
      lower_half_select_n <= 1'b1;
      upper_half_select_n <= 1'b1;
      oe_n <= 1'b1;
      we_n <= 1'b1;
      flash_reset_n <= 1'b0;
      accelerate_high_voltage <= 1'b0;
      addr_pin <= '0;
      dq_out <= '0;
      dq_oe <= 1'b0;
      page_reg <= '0;
      page_valid_reg <= 1'b0;
      sleep_cnt_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
      req_ready <= req_ready_next;
      rsp_valid <= rsp_valid_next;
      rsp_rdata <= rsp_rdata_next;
      rsp_bank <= rsp_bank_next;
      lower_half_select_n <= lo_n_next;
      upper_half_select_n <= up_n_next;
      oe_n <= oe_n_next;
      we_n <= we_n_next;
      flash_reset_n <= frst_n_next;
      accelerate_high_voltage <= acc_next;
      addr_pin <= addr_next;
      dq_out <= dq_out_next;
      dq_oe <= dq_oe_next;
      page_reg <= page_next;
      page_valid_reg <= page_valid_next;
      sleep_cnt_reg <= sleep_cnt_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  localparam int ACC_MIN = ACC_CYC;
  logic [TIMER_W-1:0] oe_low_cnt;
  logic miss_reg;
  always_ff @(posedge clk)
  begin
    if (!resetn || oe_n)
      oe_low_cnt <= '0;
    else
      oe_low_cnt <= oe_low_cnt + TIMER_W'(1);
    if (!resetn)
      miss_reg <= 1'b0;
    else if (state_reg == S_IDLE && req_valid && req_ready && !req_write)
      miss_reg <= !hit;
  end

  property p_read_we_high;
    @(posedge clk) disable iff (!resetn) !oe_n |-> we_n;
  endproperty
  a_read_we_high: assert property (p_read_we_high) else $error("we low during read");

  property p_write_oe_high;
    @(posedge clk) disable iff (!resetn)
      !we_n |-> oe_n && (!lower_half_select_n || !upper_half_select_n);
  endproperty
  a_write_oe_high: assert property (p_write_oe_high) else $error("bad write cycle");

  property p_one_half;
    @(posedge clk) disable iff (!resetn) !(!lower_half_select_n && !upper_half_select_n);
  endproperty
  a_one_half: assert property (p_one_half) else $error("both halves selected");

  property p_no_contention;
    @(posedge clk) disable iff (!resetn) dq_oe |-> oe_n;
  endproperty
  a_no_contention: assert property (p_no_contention) else $error("bus contention");

  property p_full_delay;
    @(posedge clk) disable iff (!resetn)
      rsp_valid && !$past(oe_n) && miss_reg |-> oe_low_cnt >= TIMER_W'(ACC_MIN);
  endproperty
  a_full_delay: assert property (p_full_delay) else $error("read too fast");

  property p_standby_invalid;
    @(posedge clk) disable iff (!resetn)
      $rose(lower_half_select_n && upper_half_select_n) |-> !page_valid_reg;
  endproperty
  a_standby_invalid: assert property (p_standby_invalid) else $error("page kept");

  property p_reset_quiet;
    @(posedge clk) disable iff (!resetn) !flash_reset_n |-> !dq_oe && oe_n && we_n;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("bus active in reset");

  property p_accel_follow;
    @(posedge clk) disable iff (!resetn) accelerate_high_voltage |-> $past(accel_req);
  endproperty
  a_accel_follow: assert property (p_accel_follow) else $error("stray high voltage");

  sequence s_we_rise;
    $rose(we_n) && state_reg == S_WR_HOLD;
  endsequence
  property p_data_hold;
    @(posedge clk) disable iff (!resetn) s_we_rise |-> dq_oe ##1 dq_oe;
  endproperty
  a_data_hold: assert property (p_data_hold) else $error("data not held after write");

endmodule : flash_host

// ==== flash_host_pkg.sv ====
/*
 * Constants, timing counts and decode helpers for the flash bus host.
 * Assumes a single 250 MHz clock; all timing is in whole clock cycles.
 */
package flash_host_pkg;

  localparam int CLK_PERIOD_NS = 4;
  // Device timing, ns (plain defaults, set to the speed grade in use)
  localparam int ADDRESS_ACCESS_DELAY_NS = 70;
  localparam int T_CE_NS = 70;
  localparam int T_OE_NS = 30;
  localparam int PAGE_ACCESS_DELAY_NS = 30;
  localparam int T_WP_NS = 40;
  localparam int T_WPH_NS = 30;
  localparam int T_RP_NS = 500;
  localparam int T_RH_NS = 50;
  localparam int T_SLEEP_EXTRA_NS = 150;
  // Extra cycles spent in the data input synchroniser
  localparam int SYNC_LAT = 2;
  localparam int ADDR_W = 23;
  localparam int DATA_W = 16;
  localparam int TIMER_W = 8;
  localparam int PAGE_LSB = 3;
  localparam int BANK_BITS = 3;
  localparam logic [1:0] BANK_A = 2'h0;
  localparam logic [1:0] BANK_B = 2'h1;
  localparam logic [1:0] BANK_C = 2'h2;
  localparam logic [1:0] BANK_D = 2'h3;

  // Least time rounds up, never below one cycle
  function automatic int cyc_up(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction : cyc_up

  function automatic int max2(input int a, input int b);
    return (a > b) ? a : b;
  endfunction : max2

  // Top three address bits to bank; dual variant uses bit 2 as the half
  function automatic logic [1:0] bank_of(input logic [2:0] b, input logic dual);
    logic [1:0] r;
    r = BANK_A;
    if (dual)
    begin
      if (!b[2])
        r = (b[1:0] == 2'h3) ? BANK_B : BANK_A;
      else
        r = (b[1:0] == 2'h0) ? BANK_C : BANK_D;
    end
    else
    begin
      if (b == 3'h0)
        r = BANK_A;
      else if (b == 3'h7)
        r = BANK_D;
      else if (!b[2])
        r = BANK_B;
      else
        r = BANK_C;
    end
    return r;
  endfunction : bank_of

endpackage : flash_host_pkg

// ==== flash_host_test.sv ====
/* Self-checking bench for the flash host with a device model.
   Assumes the host package; inputs change on falling edges. */
`timescale 1ns/1ns
module flash_host_test;
  import flash_host_pkg::*;
  localparam logic [15:0] ID = 16'h1234;
  localparam logic [22:0] BASE = 23'h012340;
  logic clk = 1'b0, resetn = 1'b0, req_valid = 1'b0, req_write = 1'b0;
  logic standby_req = 1'b0, reset_req = 1'b0, accel_req = 1'b0;
  logic [ADDR_W-1:0] req_addr = '0;
  logic [DATA_W-1:0] req_wdata = '0, float_val = 16'h00FF, rd, rsp_rdata, dq_out, m_data;
  logic [DATA_W-1:0] last_wdata, dq_bus;
  logic req_ready, rsp_valid, lo_n, up_n, oe_n, we_n, frst_n, ahv, dq_oe, m_drive;
  logic [1:0] rsp_bank;
  logic [ADDR_W-1:0] addr_pin;
  logic [7:0] wr_count;
  logic [1:0] bank_tbl [8] = '{BANK_A, BANK_B, BANK_B, BANK_B, BANK_C, BANK_C, BANK_C, BANK_D};
  // Dual variant: top bit picks the half, lower two bits the bank
  logic [1:0] dual_tbl [8] = '{BANK_A, BANK_A, BANK_A, BANK_B, BANK_C, BANK_D, BANK_D, BANK_D};
  int bad_count = 0, cmp_count = 0, lat;
  always #2 clk = ~clk;
  // Released wire shows a changing pattern
  always @(posedge clk) float_val <= ~float_val;
  assign dq_bus = dq_oe ? dq_out : (m_drive ? m_data : float_val);
  flash_host #(.RP_CYC(4)) uut (.clk(clk), .resetn(resetn), .req_valid(req_valid),
    .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata), .req_ready(req_ready),
    .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .rsp_bank(rsp_bank),
    .standby_req(standby_req), .reset_req(reset_req), .accel_req(accel_req),
    .lower_half_select_n(lo_n), .upper_half_select_n(up_n), .oe_n(oe_n), .we_n(we_n),
    .flash_reset_n(frst_n), .accelerate_high_voltage(ahv), .addr_pin(addr_pin),
    .dq_in(dq_bus), .dq_out(dq_out), .dq_oe(dq_oe));
  flash_model fm (.clk(clk), .lower_half_select_n(lo_n), .upper_half_select_n(up_n),
    .oe_n(oe_n), .we_n(we_n), .flash_reset_n(frst_n), .addr_pin(addr_pin), .dq_bus(dq_bus),
    .m_drive(m_drive), .m_data(m_data), .wr_count(wr_count), .last_wdata(last_wdata));
  //////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] arr(input logic [ADDR_W-1:0] a);
    return a[15:0] ^ 16'h5A3C;
  endfunction : arr
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task automatic summarize;
    if (bad_count == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : summarize
  task automatic xfer(input logic wr, input logic [22:0] a, input logic [15:0] d);
    for (int i = 0; req_ready !== 1'b1; i++)
    begin
      if (i > 400)
      begin
        bad_count++;
        summarize();
      end
      @(negedge clk);
    end
    {req_valid, req_write, req_addr, req_wdata} = {1'b1, wr, a, d};
    @(negedge clk);
    req_valid = 1'b0;
    for (lat = 1; rsp_valid !== 1'b1; lat++)
    begin
      if (lat > 400)
      begin
        bad_count++;
        summarize();
      end
      @(negedge clk);
    end
    rd = rsp_rdata;
  endtask : xfer
  always @(negedge clk)
  begin
    if (resetn)
      chk("pin_conflict", {!we_n && !oe_n, dq_oe && m_drive}, 0);
  end
  //////////////////////////////////////////////////////////////////////////
  task automatic t_page;
    xfer(0, BASE, 0);
    chk("miss_data", rd, arr(BASE));
    chk("miss_slow", lat * CLK_PERIOD_NS >= ADDRESS_ACCESS_DELAY_NS, 1);
    for (int w = 7; w > 0; w--)
    begin
      xfer(0, BASE + 23'(w), 0);
      chk("word_data", rd, arr(BASE + 23'(w)));
      chk("hit_fast", lat * CLK_PERIOD_NS < ADDRESS_ACCESS_DELAY_NS, 1);
    end
    xfer(0, BASE + 23'h8, 0);
    chk("new_page_slow", lat * CLK_PERIOD_NS >= ADDRESS_ACCESS_DELAY_NS, 1);
  endtask : t_page
  task automatic t_banks;
    for (int b = 0; b < 8; b++)
    begin
      xfer(0, {3'(b), 20'h00010}, 0);
      chk("bank", rsp_bank, bank_tbl[b]);
      chk("bank_dual", bank_of(3'(b), 1'b1), dual_tbl[b]);
      chk("bank_data", rd, arr({3'(b), 20'h00010}));
    end
  endtask : t_banks
  task automatic t_standby;
    xfer(0, BASE, 0);
    standby_req = 1'b1;
    repeat (3) @(negedge clk);
    chk("standby_pins", {lo_n, up_n, dq_oe, m_drive}, 4'hC);
    standby_req = 1'b0;
    xfer(0, BASE + 23'h1, 0);
    chk("reselect_slow", lat * CLK_PERIOD_NS >= ADDRESS_ACCESS_DELAY_NS, 1);
    chk("reselect_data", rd, arr(BASE + 23'h1));
  endtask : t_standby
  task automatic t_sleep;
    xfer(0, BASE, 0);
    repeat (70) @(negedge clk);
    xfer(0, BASE + 23'h2, 0);
    chk("wake_slow", lat * CLK_PERIOD_NS >= ADDRESS_ACCESS_DELAY_NS, 1);
    chk("wake_data", rd, arr(BASE + 23'h2));
  endtask : t_sleep
  task automatic t_cmd;
    logic [7:0] n0;
    n0 = wr_count;
    xfer(1, 23'h000555, 16'h00AA);
    xfer(1, 23'h0002AA, 16'h0055);
    xfer(1, 23'h000555, 16'h0090);
    chk("cmd_writes", {wr_count, last_wdata}, {n0 + 8'h03, 16'h0090});
    xfer(0, 23'h000001, 0);
    chk("ident", rd, ID);
    xfer(1, 23'h000000, 16'h00F0);
    xfer(0, BASE, 0);
    chk("array_again", rd, arr(BASE));
    accel_req = 1'b1;
    repeat (2) @(negedge clk);
    chk("accel_on", ahv, 1);
    xfer(1, 23'h000555, 16'h00A0);
    xfer(1, 23'h700020, 16'hBEEF);
    chk("bypass_prog", {wr_count, last_wdata}, {n0 + 8'h06, 16'hBEEF});
    accel_req = 1'b0;
    repeat (2) @(negedge clk);
    chk("accel_off", ahv, 0);
  endtask : t_cmd
  task automatic t_hwreset;
    xfer(1, 23'h000555, 16'h0090);
    reset_req = 1'b1;
    for (int i = 0; frst_n !== 1'b0 && i < 20; i++) @(negedge clk);
    chk("reset_pin", {frst_n, m_drive}, 0);
    reset_req = 1'b0;
    xfer(0, BASE + 23'h3, 0);
    chk("reset_array", rd, arr(BASE + 23'h3));
  endtask : t_hwreset
  //////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (4) @(negedge clk);
    chk("reset_pins", {frst_n, lo_n, up_n, dq_oe, ahv, req_ready}, 6'h18);
    resetn = 1'b1;
    t_page();
    t_banks();
    t_standby();
    t_sleep();
    t_cmd();
    t_hwreset();
    summarize();
  end
endmodule : flash_host_test

// ==== flash_model.sv ====
/* Behavioural flash device standing on the far side of the host.
   Assumes host pins are wired straight in; dq_bus is the resolved data wire. */
`timescale 1ns/1ns
module flash_model
  import flash_host_pkg::*;
#(
  parameter bit DUAL = 1'b0,
  // Arbitrary identification value
  parameter logic [15:0] ID_CODE = 16'h1234
)
(
  input wire logic clk,
  input wire logic lower_half_select_n,
  input wire logic upper_half_select_n,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic flash_reset_n,
  input wire logic [ADDR_W-1:0] addr_pin,
  input wire logic [DATA_W-1:0] dq_bus,
  output logic m_drive,
  output logic [DATA_W-1:0] m_data,
  output logic [7:0] wr_count,
  output logic [DATA_W-1:0] last_wdata
);
  logic sel_ok, hit, page_ok, valid, autosel;
  logic [ADDR_W-4:0] page_reg;
  time t_addr, t_oe;
  initial
  begin
    {hit, page_ok, autosel, m_drive} = 4'h0;
    m_data = 16'h00FF;
    wr_count = 8'h00;
    page_reg = '0;
    t_addr = 0;
    t_oe = 0;
  end
  //////////////////////////////////////////////////////////////////////////
  // half select
  assign sel_ok = (DUAL && addr_pin[ADDR_W-1]) ? !upper_half_select_n : !lower_half_select_n;
  always @(addr_pin or sel_ok)
  begin
    hit = page_ok && sel_ok && addr_pin[ADDR_W-1:3] == page_reg
          && ($time - t_addr) < ADDRESS_ACCESS_DELAY_NS + T_SLEEP_EXTRA_NS;
    t_addr = $time;
  end
  always @(negedge oe_n)
    t_oe = $time;
  always @(negedge clk)
  begin
    valid = ($time - t_addr) >= (hit ? PAGE_ACCESS_DELAY_NS : ADDRESS_ACCESS_DELAY_NS) && ($time - t_oe) >= T_OE_NS;
    m_drive = flash_reset_n && sel_ok && !oe_n && we_n;
    if (!flash_reset_n)
      autosel = 1'b0;
    if (!flash_reset_n || (lower_half_select_n && upper_half_select_n))
      page_ok = 1'b0;
    else if (m_drive && valid)
    begin
      page_reg = addr_pin[ADDR_W-1:3];
      page_ok = 1'b1;
    end
    // Unsettled data toggles so a sampler never sees it agree
    m_data = (m_drive && valid) ? (autosel ? ID_CODE : addr_pin[15:0] ^ 16'h5A3C) : ~m_data;
  end
  //////////////////////////////////////////////////////////////////////////
  // command cycles
  always @(posedge we_n)
    if (flash_reset_n === 1'b1 && sel_ok && oe_n)
    begin
      wr_count = wr_count + 8'h01;
      last_wdata = dq_bus;
      if (dq_bus == 16'h0090)
        autosel = 1'b1;
      else if (dq_bus == 16'h00F0)
        autosel = 1'b0;
    end
endmodule : flash_model
